// *** drpt_pkg.sv ***
// Shared constants and types for the read preamble training link
package drpt_pkg;
// Behaviour
// - Enable parks true strobe low, complement high
// - No normal read preamble while training
// - Calibration read drives like ordinary read burst
// - Data lines undefined before first calibration
// - Controller sends only calibration while training; code also lets MR_TRAIN_CTRL mode writes through
// - Calibration command directly followed by CAS-2
// - Sixteen bits: first byte then second byte
// - Inverted pattern on pins with mask set
// - Pattern on mask pins, never bus-inverted
// - Pairs repeat every tCCD, bursts seamless
// - CAS-2 operands after calibration all low
// - Clearing enable exits training within tSDO
// - Calibration reads use burst sixteen only
	localparam int DQ_W = 16;
	localparam int DMI_W = 2;
	localparam int BURST_LEN = 16;
	typedef enum logic [2:0] {
		CMD_NOP     = 3'h0,
		CMD_MRW     = 3'h1,
		CMD_MPC_RDC = 3'h2,
		CMD_CAS2    = 3'h3
	} drpt_cmd_t;
	localparam logic [7:0] MR_TRAIN_CTRL = 8'h0D;
	localparam logic [7:0] MR_PAT_FIRST  = 8'h20;
	localparam logic [7:0] MR_PAT_SECOND = 8'h28;
	localparam logic [7:0] MR_INV_LO     = 8'h0F;
	localparam logic [7:0] MR_INV_HI     = 8'h14;
	localparam logic [7:0] MR_RST        = 8'h00;
	localparam int TRAIN_EN_BIT = 1;
	localparam int RL_CYC = 8;
	localparam int RL_PIPE = RL_CYC - 2;
	localparam logic [2:0] T_SDO_CYC = 3'h4;
	localparam int TCCD_CYC = BURST_LEN;
	localparam logic [4:0] GAP_LOAD = 5'(TCCD_CYC - 3);
	localparam logic [3:0] BIT_LAST = 4'(BURST_LEN - 1);
	localparam int REF_PERIOD_PS = 5000;
	localparam int LNK_DIV = 4;
	localparam logic [1:0] DIV_LAST = 2'(LNK_DIV - 1);
	localparam logic [1:0] REG_CMD = 2'h0;
	localparam logic [1:0] REG_STATUS = 2'h1;
	localparam logic [1:0] REG_CAP_DQ = 2'h2;
	localparam logic [1:0] REG_CAP_DMI = 2'h3;
	localparam int CMD_KIND_LSB = 0;
	localparam int CMD_ADDR_LSB = 8;
	localparam int CMD_DATA_LSB = 16;
	localparam logic [1:0] KIND_MRW = 2'h1;
	localparam logic [1:0] KIND_CAL = 2'h2;
	localparam int ST_BUSY = 0;
	localparam int ST_DONE = 1;
	localparam int ST_TRAIN = 2;
	localparam int ST_REFUSED = 3;
	typedef enum logic [1:0] {
		SQ_IDLE = 2'b00,
		SQ_CAS  = 2'b01,
		SQ_GAP  = 2'b11
	} drpt_seq_t;
endpackage : drpt_pkg

// *** drpt_lnk_if.sv ***
// Command and data link between controller end and memory end
`timescale 1ns/100ps
interface drpt_lnk_if;
	import drpt_pkg::*;
	logic                   ck;
	drpt_cmd_t              cmd;
	logic [7:0]             ca_addr;
	logic [7:0]             ca_data;
	logic [DQ_W-1:0]        dq_o;
	logic                   dq_oe;
	logic [DMI_W-1:0]       dmi_o;
	logic                   dmi_oe;
	logic                   dqs_t_o;
	logic                   dqs_c_o;
	logic                   dqs_oe;
	logic [DQ_W-1:0]        dq;
	logic [DMI_W-1:0]       dmi;
	logic                   dqs_t;
	logic                   dqs_c;
	// Undriven lines settle low, as with termination to ground
	assign dq    = dq_oe ? dq_o : '0;
	assign dmi   = dmi_oe ? dmi_o : '0;
	assign dqs_t = dqs_oe ? dqs_t_o : 1'b0;
	assign dqs_c = dqs_oe ? dqs_c_o : 1'b0;
	modport dram (
		input  ck, cmd, ca_addr, ca_data,
		output dq_o, dq_oe, dmi_o, dmi_oe, dqs_t_o, dqs_c_o, dqs_oe
	);
	modport ctrl (
		output ck, cmd, ca_addr, ca_data,
		input  dq, dmi, dqs_t, dqs_c
	);
endinterface : drpt_lnk_if

// *** drpt_burst_ser.sv ***
// Sixteen-bit burst serialiser, lowest bit first
`timescale 1ns/100ps
module drpt_burst_ser
	import drpt_pkg::*;
(
	input  wire logic                 i_clk,
	input  wire logic                 i_arst_n,
	input  wire logic                 i_load,
	input  wire logic [BURST_LEN-1:0] i_pattern,
	output logic                      o_valid,
	output logic                      o_bit,
	output logic                      o_odd
);
	logic [BURST_LEN-1:0] sh_q;
	logic [3:0]           idx_q;
	logic                 valid_q;

	// A load on the last bit continues without a gap
	always_ff @(posedge i_clk or negedge i_arst_n)
	begin
		if (!i_arst_n)
		begin
			sh_q    <= '0;
			idx_q   <= 4'h0;
			valid_q <= 1'b0;
		end
		else if (i_load)
		begin
			sh_q    <= i_pattern;
			idx_q   <= 4'h0;
			valid_q <= 1'b1;
		end
		else if (valid_q)
		begin
			sh_q  <= {1'b0, sh_q[BURST_LEN-1:1]};
			idx_q <= idx_q + 4'h1;
			if (idx_q == BIT_LAST)
				valid_q <= 1'b0;
		end
	end

	assign o_valid = valid_q;
	assign o_bit   = sh_q[0];
	assign o_odd   = idx_q[0];
endmodule : drpt_burst_ser

// *** drpt_dram_end.sv ***
// Memory end: mode settings, training strobe park, calibration bursts
`timescale 1ns/100ps
module drpt_dram_end
	import drpt_pkg::*;
(
	input  wire logic  i_arst_n,
	drpt_lnk_if.dram   lnk,
	output logic       o_train_active,
	output logic       o_burst_active,
	output logic       o_cmd_fault
);
	logic [7:0]         pat_first_q;
	logic [7:0]         pat_second_q;
	logic [7:0]         inv_lo_q;
	logic [7:0]         inv_hi_q;
	logic               train_en_q;
	logic               train_q;
	logic [2:0]         sdo_cnt_q;
	logic               mpc_seen_q;
	logic               start;
	logic [RL_PIPE-1:0] rl_q;
	logic               load;
	logic [DQ_W-1:0]    inv_q;
	logic               ser_valid;
	logic               ser_bit;
	logic               ser_odd;
	logic [DQ_W-1:0]    dq_q;
	logic               dq_oe_q;
	logic [DMI_W-1:0]   dmi_q;
	logic               dqs_t_q;
	logic               dqs_c_q;
	logic               dqs_oe_q;
	logic               fault_q;

	// Settings change only by mode register writes
	always_ff @(posedge lnk.ck or negedge i_arst_n)
	begin
		if (!i_arst_n)
		begin
			pat_first_q  <= MR_RST;
			pat_second_q <= MR_RST;
			inv_lo_q     <= MR_RST;
			inv_hi_q     <= MR_RST;
			train_en_q   <= 1'b0;
		end
		else if (lnk.cmd == CMD_MRW)
		begin
			case (lnk.ca_addr)
				MR_TRAIN_CTRL:
					train_en_q <= lnk.ca_data[TRAIN_EN_BIT];
				MR_PAT_FIRST:
					pat_first_q <= lnk.ca_data;
				MR_PAT_SECOND:
					pat_second_q <= lnk.ca_data;
				MR_INV_LO:
					inv_lo_q <= lnk.ca_data;
				MR_INV_HI:
					inv_hi_q <= lnk.ca_data;
				default:
					pat_first_q <= pat_first_q;
			endcase
		end
	end

	// Mode change takes effect a fixed tSDO after the write
	always_ff @(posedge lnk.ck or negedge i_arst_n)
	begin
		if (!i_arst_n)
		begin
			train_q   <= 1'b0;
			sdo_cnt_q <= 3'h0;
		end
		else if (train_en_q != train_q)
		begin
			// Strobe flop adds a cycle, so switch one early to meet tSDO
			if (sdo_cnt_q == T_SDO_CYC - 3'h2)
			begin
				train_q   <= train_en_q;
				sdo_cnt_q <= 3'h0;
			end
			else
			begin
				sdo_cnt_q <= sdo_cnt_q + 3'h1;
			end
		end
		else
		begin
			sdo_cnt_q <= 3'h0;
		end
	end

	// A calibration command only counts when CAS-2 follows at once
	always_ff @(posedge lnk.ck or negedge i_arst_n)
	begin
		if (!i_arst_n)
			mpc_seen_q <= 1'b0;
		else
			mpc_seen_q <= train_q && (lnk.cmd == CMD_MPC_RDC);
	end

	// Nonzero operands would ask for another burst length
	assign start = mpc_seen_q && (lnk.cmd == CMD_CAS2)
		&& (lnk.ca_data == 8'h00);

	// Flag, held until training ends, for a stray CAS-2 or a mode write other than control while training
	always_ff @(posedge lnk.ck or negedge i_arst_n)
	begin
		if (!i_arst_n)
			fault_q <= 1'b0;
		else if (!train_q)
			fault_q <= 1'b0;
		else if (lnk.cmd == CMD_CAS2 && !start)
			fault_q <= 1'b1;
		else if (lnk.cmd == CMD_MRW
			&& lnk.ca_addr != MR_TRAIN_CTRL)
			fault_q <= 1'b1;
	end

	// Read latency pipeline; one bit per pair in flight
	always_ff @(posedge lnk.ck or negedge i_arst_n)
	begin
		if (!i_arst_n)
			rl_q <= '0;
		else
			rl_q <= {rl_q[RL_PIPE-2:0], start};
	end

	assign load = rl_q[RL_PIPE-1];

	// Mask sampled at burst start so mid-burst writes cannot tear it
	always_ff @(posedge lnk.ck or negedge i_arst_n)
	begin
		if (!i_arst_n)
			inv_q <= '0;
		else if (load)
			inv_q <= {inv_hi_q, inv_lo_q};
	end

	drpt_burst_ser u_ser (
		.i_clk     (lnk.ck),
		.i_arst_n  (i_arst_n),
		.i_load    (load),
		.i_pattern ({pat_second_q, pat_first_q}),
		.o_valid   (ser_valid),
		.o_bit     (ser_bit),
		.o_odd     (ser_odd)
	);

	// Data lines float until the first calibration burst
	always_ff @(posedge lnk.ck or negedge i_arst_n)
	begin
		if (!i_arst_n)
		begin
			dq_q    <= '0;
			dq_oe_q <= 1'b0;
			dmi_q   <= '0;
		end
		else
		begin
			dq_q    <= {DQ_W{ser_bit}} ^ inv_q;
			dq_oe_q <= ser_valid;
			dmi_q   <= {DMI_W{ser_bit}};
		end
	end

	// Strobe parked static in training; toggles only with data
	always_ff @(posedge lnk.ck or negedge i_arst_n)
	begin
		if (!i_arst_n)
		begin
			dqs_t_q  <= 1'b0;
			dqs_c_q  <= 1'b0;
			dqs_oe_q <= 1'b0;
		end
		else if (ser_valid)
		begin
			dqs_t_q  <= ~ser_odd;
			dqs_c_q  <= ser_odd;
			dqs_oe_q <= 1'b1;
		end
		else if (train_q)
		begin
			dqs_t_q  <= 1'b0;
			dqs_c_q  <= 1'b1;
			dqs_oe_q <= 1'b1;
		end
		else
		begin
			dqs_t_q  <= 1'b0;
			dqs_c_q  <= 1'b0;
			dqs_oe_q <= 1'b0;
		end
	end

	assign lnk.dq_o    = dq_q;
	assign lnk.dq_oe   = dq_oe_q;
	assign lnk.dmi_o   = dmi_q;
	assign lnk.dmi_oe  = dq_oe_q;
	assign lnk.dqs_t_o = dqs_t_q;
	assign lnk.dqs_c_o = dqs_c_q;
	assign lnk.dqs_oe  = dqs_oe_q;

	assign o_train_active = train_q;
	assign o_burst_active = dq_oe_q;
	assign o_cmd_fault    = fault_q;
endmodule : drpt_dram_end

// *** drpt_ctrl_end.sv ***
// Controller end: register slave, command sequencer, burst capture
`timescale 1ns/100ps
module drpt_ctrl_end
	import drpt_pkg::*;
(
	input  wire logic        i_ref_clk,
	input  wire logic        i_arst_n,
	input  wire logic        i_hsel,
	input  wire logic [31:0] i_haddr,
	input  wire logic [1:0]  i_htrans,
	input  wire logic        i_hwrite,
	input  wire logic [2:0]  i_hsize,
	input  wire logic [31:0] i_hwdata,
	input  wire logic        i_hready,
	output logic [31:0]      o_hrdata,
	output logic             o_hreadyout,
	output logic             o_hresp,
	drpt_lnk_if.ctrl         lnk
);
	logic [1:0]  div_q;
	logic        rdy_q;
	logic        tick;
	logic        wr_q;
	logic [2:0]  wdec_q;
	logic [31:0] hrdata_q;
	logic        req_q;
	logic [1:0]  kind_q;
	logic [7:0]  addr_q;
	logic [7:0]  data_q;
	logic        train_q;
	logic        done_q;
	logic        refused_q;
	logic        busy;
	logic        bad;
	drpt_seq_t   st_q;
	logic [4:0]  gap_q;
	drpt_cmd_t   cmd_q;
	logic [7:0]  ca_addr_q;
	logic [7:0]  ca_data_q;
	logic [3:0]  s1_q;
	logic [3:0]  s2_q;
	logic        dqs_s3_q;
	logic        edge_hit;
	logic [3:0]  bit_q;
	logic [15:0] sh0_q;
	logic [15:0] sh8_q;
	logic [15:0] shm_q;
	logic [31:0] cap_dq_q;
	logic [15:0] cap_dmi_q;

	// Decode: {hit, word index}
	function automatic logic [2:0] reg_dec(input logic [31:0] a);
		reg_dec = {a[31:4] == 28'h0, a[3:2]};
	endfunction : reg_dec

	// Link clock is a divided copy; commands change on its fall
	always_ff @(posedge i_ref_clk or negedge i_arst_n)
	begin
		if (!i_arst_n)
			div_q <= 2'h0;
		else
			div_q <= div_q + 2'h1;
	end
	assign tick = (div_q == DIV_LAST);

	// Ready from a flop; no wait states once out of reset
	always_ff @(posedge i_ref_clk or negedge i_arst_n)
	begin
		if (!i_arst_n)
			rdy_q <= 1'b0;
		else
			rdy_q <= 1'b1;
	end

	always_ff @(posedge i_ref_clk or negedge i_arst_n)
	begin
		if (!i_arst_n)
		begin
			wr_q     <= 1'b0;
			wdec_q   <= 3'h0;
			hrdata_q <= 32'h0;
		end
		else
		begin
			wr_q <= i_hsel & i_hready & i_htrans[1] & i_hwrite;
			wdec_q <= reg_dec(i_haddr);
			if (i_hsel & i_hready & i_htrans[1] & ~i_hwrite)
			begin
				case (reg_dec(i_haddr))
					{1'b1, REG_CMD}:
						hrdata_q <= {8'h00, data_q, addr_q, 6'h00, kind_q};
					{1'b1, REG_STATUS}:
						hrdata_q <= {28'h0, refused_q, train_q, done_q, busy};
					{1'b1, REG_CAP_DQ}:
						hrdata_q <= cap_dq_q;
					{1'b1, REG_CAP_DMI}:
						hrdata_q <= {16'h0, cap_dmi_q};
					default:
						hrdata_q <= 32'h0;
				endcase
			end
		end
	end

	assign busy = req_q | (st_q != SQ_IDLE);
	assign bad = busy
		| (i_hwdata[1:0] == KIND_CAL & ~train_q)
		| (i_hwdata[1:0] == KIND_MRW & train_q
			& i_hwdata[15:8] != MR_TRAIN_CTRL)
		| (i_hwdata[1:0] != KIND_CAL & i_hwdata[1:0] != KIND_MRW);

	// Order intake and sticky flags; a new event beats a clear
	always_ff @(posedge i_ref_clk or negedge i_arst_n)
	begin
		if (!i_arst_n)
		begin
			req_q <= 1'b0;
			kind_q <= 2'h0;
			addr_q <= 8'h00;
			data_q <= 8'h00;
			refused_q <= 1'b0;
		end
		else if (wr_q && wdec_q == {1'b1, REG_CMD})
		begin
			if (bad)
				refused_q <= 1'b1;
			else
			begin
				req_q <= 1'b1;
				kind_q <= i_hwdata[CMD_KIND_LSB+:2];
				addr_q <= i_hwdata[CMD_ADDR_LSB+:8];
				data_q <= i_hwdata[CMD_DATA_LSB+:8];
			end
		end
		else
		begin
			if (tick && st_q == SQ_IDLE)
				req_q <= 1'b0;
			if (wr_q && wdec_q == {1'b1, REG_STATUS} && i_hwdata[ST_REFUSED])
				refused_q <= 1'b0;
		end
	end

	// Sequencer: pair of commands, then a gap fixing tCCD spacing
	always_ff @(posedge i_ref_clk or negedge i_arst_n)
	begin
		if (!i_arst_n)
		begin
			st_q <= SQ_IDLE;
			gap_q <= 5'h0;
			cmd_q <= CMD_NOP;
			ca_addr_q <= 8'h00;
			ca_data_q <= 8'h00;
			train_q <= 1'b0;
		end
		else if (tick)
		begin
			cmd_q <= CMD_NOP;
			ca_addr_q <= 8'h00;
			ca_data_q <= 8'h00;
			case (st_q)
				SQ_IDLE:
					if (req_q && kind_q == KIND_MRW)
					begin
						cmd_q <= CMD_MRW;
						ca_addr_q <= addr_q;
						ca_data_q <= data_q;
						if (addr_q == MR_TRAIN_CTRL)
							train_q <= data_q[TRAIN_EN_BIT];
					end
					else if (req_q)
					begin
						cmd_q <= CMD_MPC_RDC;
						st_q <= SQ_CAS;
					end
				SQ_CAS:
				begin
					cmd_q <= CMD_CAS2;
					gap_q <= GAP_LOAD;
					st_q <= SQ_GAP;
				end
				SQ_GAP:
					if (gap_q == 5'h0)
						st_q <= SQ_IDLE;
					else
						gap_q <= gap_q - 5'h1;
				default:
					st_q <= SQ_IDLE;
			endcase
		end
	end

	// Returning lines are asynchronous: two flops before use
	always_ff @(posedge i_ref_clk or negedge i_arst_n)
	begin
		if (!i_arst_n)
		begin
			s1_q <= 4'h0;
			s2_q <= 4'h0;
			dqs_s3_q <= 1'b0;
		end
		else
		begin
			s1_q <= {lnk.dqs_t, lnk.dmi[0], lnk.dq[8], lnk.dq[0]};
			s2_q <= s1_q;
			dqs_s3_q <= s2_q[3];
		end
	end
	assign edge_hit = s2_q[3] ^ dqs_s3_q;

	// One strobe change per bit; lines before the first burst ignored
	always_ff @(posedge i_ref_clk or negedge i_arst_n)
	begin
		if (!i_arst_n)
		begin
			bit_q <= 4'h0;
			sh0_q <= 16'h0;
			sh8_q <= 16'h0;
			shm_q <= 16'h0;
			cap_dq_q <= 32'h0;
			cap_dmi_q <= 16'h0;
			done_q <= 1'b0;
		end
		else
		begin
			if (edge_hit)
			begin
				bit_q <= bit_q + 4'h1;
				sh0_q <= {s2_q[0], sh0_q[15:1]};
				sh8_q <= {s2_q[1], sh8_q[15:1]};
				shm_q <= {s2_q[2], shm_q[15:1]};
			end
			if (edge_hit && bit_q == BIT_LAST)
			begin
				cap_dq_q <= {s2_q[1], sh8_q[15:1], s2_q[0], sh0_q[15:1]};
				cap_dmi_q <= {s2_q[2], shm_q[15:1]};
				done_q <= 1'b1;
			end
			else if (wr_q && wdec_q == {1'b1, REG_STATUS}
				&& i_hwdata[ST_DONE])
				done_q <= 1'b0;
		end
	end

	assign lnk.ck = div_q[1];
	assign lnk.cmd = cmd_q;
	assign lnk.ca_addr = ca_addr_q;
	assign lnk.ca_data = ca_data_q;
	assign o_hrdata = hrdata_q;
	assign o_hreadyout = rdy_q;
	assign o_hresp = 1'b0;
endmodule : drpt_ctrl_end

// *** drpt_props.sv ***
// Link-side assertions for read preamble training
`timescale 1ns/100ps
module drpt_props
	import drpt_pkg::*;
(
	input  wire logic             i_arst_n,
	input  wire logic             ck,
	input  wire drpt_cmd_t        cmd,
	input  wire logic [7:0]       ca_addr,
	input  wire logic [7:0]       ca_data,
	input  wire logic [DQ_W-1:0]  dq,
	input  wire logic             dq_oe,
	input  wire logic [DMI_W-1:0] dmi,
	input  wire logic             dmi_oe,
	input  wire logic             dqs_t,
	input  wire logic             dqs_c,
	input  wire logic             dqs_oe
);
	default clocking cb @(posedge ck);
	endclocking
	default disable iff (!i_arst_n);
	property p_cas_ops;
		cmd == CMD_CAS2 |-> ca_addr == 8'h00 && ca_data == 8'h00;
	endproperty
	a_cas_ops: assert property (p_cas_ops)
		else $error("CAS2 operands not low");
	property p_pair;
		cmd == CMD_MPC_RDC |=> cmd == CMD_CAS2;
	endproperty
	a_pair: assert property (p_pair)
		else $error("Calibration not followed by CAS2");
	property p_latency;
		cmd == CMD_CAS2 && $past(cmd) == CMD_MPC_RDC |-> ##[8:10] dq_oe;
	endproperty
	a_latency: assert property (p_latency)
		else $error("Burst missing after read latency");
	property p_len;
		$rose(dq_oe) |-> dq_oe[*8] ##1 dq_oe[*8];
	endproperty
	a_len: assert property (p_len)
		else $error("Burst shorter than sixteen bits");
	// Parked strobes also prove the preamble is suppressed
	property p_park;
		dqs_oe && !dq_oe |-> !dqs_t && dqs_c;
	endproperty
	a_park: assert property (p_park)
		else $error("Strobes not parked outside burst");
	property p_toggle;
		dq_oe && $past(dq_oe) |-> dqs_t != $past(dqs_t) && dqs_c == !dqs_t;
	endproperty
	a_toggle: assert property (p_toggle)
		else $error("Strobe not toggling in burst");
	property p_dmi;
		dq_oe |-> dmi_oe && dmi[0] == dmi[1];
	endproperty
	a_dmi: assert property (p_dmi)
		else $error("Mask pins not carrying pattern");
	property p_enter;
		cmd == CMD_MRW && ca_addr == MR_TRAIN_CTRL
			&& ca_data[TRAIN_EN_BIT] && !dqs_oe |-> ##[3:5] dqs_oe;
	endproperty
	a_enter: assert property (p_enter)
		else $error("Strobe park late after enable");
	property p_exit;
		cmd == CMD_MRW && ca_addr == MR_TRAIN_CTRL && !ca_data[TRAIN_EN_BIT]
			&& dqs_oe && !dq_oe |-> ##[3:5] !dqs_oe;
	endproperty
	a_exit: assert property (p_exit)
		else $error("Training not left after clear");
	property p_only_cal;
		dqs_oe && cmd == CMD_MRW |-> ca_addr == MR_TRAIN_CTRL;
	endproperty
	a_only_cal: assert property (p_only_cal)
		else $error("Mode write other than control in training");
endmodule : drpt_props

// *** dram_read_preamble_training_tb.sv ***
// Testbench joining controller end and memory end over the link
`timescale 1ns/100ps
module dram_read_preamble_training_tb
	import drpt_pkg::*;
;
	typedef struct packed {
		logic [31:0] mr;
		logic [31:0] dq;
		logic [15:0] dmi;
	} drpt_row_t;
	// Row: first, second, mask lo, mask hi; expected dq0/dq8 and dmi0
	localparam drpt_row_t ROWS [4] = '{
		'{32'h5AC30000, 32'hC35AC35A, 16'hC35A},
		'{32'h00FF0100, 32'hFF0000FF, 16'hFF00},
		'{32'h817E0001, 32'h817E7E81, 16'h7E81},
		'{32'h0FF0FEFF, 32'h0FF0F00F, 16'hF00F}};
	localparam logic [31:0] A_CMD = {28'h0, REG_CMD, 2'h0};
	localparam logic [31:0] A_ST  = {28'h0, REG_STATUS, 2'h0};
	localparam logic [31:0] A_DQ  = {28'h0, REG_CAP_DQ, 2'h0};
	localparam logic [31:0] A_DMI = {28'h0, REG_CAP_DMI, 2'h0};
	localparam logic [7:0]  T_ON  = 8'(1 << TRAIN_EN_BIT);
	localparam int          SDO_W = (int'(T_SDO_CYC) + 3) * LNK_DIV;
	logic        i_ref_clk;
	logic        i_arst_n;
	logic        hsel;
	logic        hwrite;
	logic [1:0]  htrans;
	logic [31:0] haddr;
	logic [31:0] hwdata;
	logic [31:0] hrdata;
	logic        hrdy;
	logic        train;
	logic        fault;
	logic        burst;
	logic [31:0] r;
	int          err_count;
	int          tests_run;
	drpt_lnk_if drpt_lnk_if_i();
	drpt_ctrl_end drpt_ctrl_end_i (.i_ref_clk(i_ref_clk), .i_arst_n(i_arst_n),
		.i_hsel(hsel), .i_haddr(haddr), .i_htrans(htrans), .i_hwrite(hwrite),
		.i_hsize(3'h2), .i_hwdata(hwdata), .i_hready(hrdy), .o_hrdata(hrdata),
		.o_hreadyout(hrdy), .o_hresp(), .lnk(drpt_lnk_if_i.ctrl));
	drpt_dram_end drpt_dram_end_i (.i_arst_n(i_arst_n),
		.lnk(drpt_lnk_if_i.dram), .o_train_active(train),
		.o_burst_active(burst), .o_cmd_fault(fault));
	drpt_props drpt_props_i (.i_arst_n(i_arst_n), .ck(drpt_lnk_if_i.ck),
		.cmd(drpt_lnk_if_i.cmd), .ca_addr(drpt_lnk_if_i.ca_addr),
		.ca_data(drpt_lnk_if_i.ca_data), .dq(drpt_lnk_if_i.dq),
		.dq_oe(drpt_lnk_if_i.dq_oe), .dmi(drpt_lnk_if_i.dmi),
		.dmi_oe(drpt_lnk_if_i.dmi_oe), .dqs_t(drpt_lnk_if_i.dqs_t),
		.dqs_c(drpt_lnk_if_i.dqs_c), .dqs_oe(drpt_lnk_if_i.dqs_oe));
	initial
	begin
		i_ref_clk = 1'b0;
		forever #2.5 i_ref_clk = ~i_ref_clk;
	end
	task automatic stop_test;
		$display("Comparisons %0d, mismatches %0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : stop_test
	task automatic chk(input string nm, input logic [31:0] e,
		input logic [31:0] g);
		tests_run++;
		if (g !== e)
		begin
			err_count++;
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	// Bounded wait for hready at a rising edge
	task automatic hwait;
		int n;
		n = 0;
		@(posedge i_ref_clk);
		while (hrdy !== 1'b1)
		begin
			n++;
			if (n > 50)
			begin
				err_count++;
				stop_test;
			end
			@(posedge i_ref_clk);
		end
	endtask : hwait
	task automatic xfer(input logic w, input logic [31:0] a, d,
		output logic [31:0] q);
		hsel <= 1'b1;
		haddr <= a;
		htrans <= 2'h2;
		hwrite <= w;
		hwait;
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		hwait;
		q = hrdata;
	endtask : xfer
	task automatic poll(input int b, input logic v);
		logic [31:0] s;
		int          n;
		n = 0;
		xfer(1'b0, A_ST, 32'h0, s);
		while (s[b] !== v)
		begin
			n++;
			if (n > 400)
			begin
				err_count++;
				stop_test;
			end
			xfer(1'b0, A_ST, 32'h0, s);
		end
	endtask : poll
	task automatic issue(input logic [1:0] k, input logic [7:0] a, d);
		logic [31:0] q;
		xfer(1'b1, A_CMD, {8'h00, d, a, 6'h00, k}, q);
		poll(ST_BUSY, 1'b0);
	endtask : issue
	task automatic cal_check(input logic [31:0] edq, input logic [15:0] edm);
		logic [31:0] q;
		issue(KIND_CAL, 8'h00, 8'h00);
		poll(ST_DONE, 1'b1);
		chk("burst_idle", 32'h0, {31'h0, burst});
		xfer(1'b0, A_DQ, 32'h0, q);
		chk("cap_dq", edq, q);
		xfer(1'b0, A_DMI, 32'h0, q);
		chk("cap_dmi", {16'h0, edm}, q);
		xfer(1'b1, A_ST, 32'h2, q);
	endtask : cal_check
	task automatic train_set(input logic [7:0] v);
		issue(KIND_MRW, MR_TRAIN_CTRL, v);
		repeat (SDO_W) @(posedge i_ref_clk);
	endtask : train_set
	initial
	begin
		#400000;
		err_count++;
		stop_test;
	end
	initial
	begin
		i_arst_n <= 1'b0;
		hsel = 1'b0;
		hwrite = 1'b0;
		htrans = 2'h0;
		haddr = 32'h0;
		hwdata = 32'h0;
		err_count = 0;
		tests_run = 0;
		repeat (5) @(posedge i_ref_clk);
		i_arst_n <= 1'b1;
		@(posedge i_ref_clk);
		for (int i = 0; i < 4; i++)
		begin
			issue(KIND_MRW, MR_PAT_FIRST, ROWS[i].mr[31:24]);
			issue(KIND_MRW, MR_PAT_SECOND, ROWS[i].mr[23:16]);
			issue(KIND_MRW, MR_INV_LO, ROWS[i].mr[15:8]);
			issue(KIND_MRW, MR_INV_HI, ROWS[i].mr[7:0]);
			train_set(T_ON);
			chk("train_on", 32'h1, {31'h0, train});
			cal_check(ROWS[i].dq, ROWS[i].dmi);
			train_set(8'h00);
			chk("train_off", 32'h0, {31'h0, train});
			$display("Row %0d finished", i);
		end
		// Calibration outside training is refused
		issue(KIND_CAL, 8'h00, 8'h00);
		xfer(1'b0, A_ST, 32'h0, r);
		chk("refused_cal", 32'h8, r & 32'hC);
		xfer(1'b1, A_ST, 32'h8, r);
		$display("Refusal test finished");
		// Pattern write in training refused; two later separate bursts unchanged
		train_set(T_ON);
		issue(KIND_MRW, MR_PAT_FIRST, 8'h00);
		xfer(1'b0, A_ST, 32'h0, r);
		chk("refused_mrw", 32'hC, r & 32'hC);
		xfer(1'b1, A_ST, 32'h8, r);
		cal_check(ROWS[3].dq, ROWS[3].dmi);
		cal_check(ROWS[3].dq, ROWS[3].dmi);
		chk("fault", 32'h0, {31'h0, fault});
		train_set(8'h00);
		$display("Training refusal test finished");
		// Unmapped place and command readback
		xfer(1'b1, 32'h10, 32'hFFFFFFFF, r);
		xfer(1'b0, 32'h10, 32'h0, r);
		chk("unmapped", 32'h0, r);
		xfer(1'b0, A_CMD, 32'h0, r);
		chk("cmd_back", {16'h0, MR_TRAIN_CTRL, 6'h00, KIND_MRW}, r);
		$display("Map test finished");
		// Reset in mid-run
		i_arst_n <= 1'b0;
		repeat (5 * LNK_DIV) @(posedge i_ref_clk);
		i_arst_n <= 1'b1;
		@(posedge i_ref_clk);
		xfer(1'b0, A_ST, 32'h0, r);
		chk("status_rst", 32'h0, r);
		chk("train_rst", 32'h0, {31'h0, train});
		$display("Reset test finished");
		stop_test;
	end
endmodule : dram_read_preamble_training_tb
